// ---- hdl/dpac_pkg.sv ----
// Shared constants and types for the dual-port RAM port controller
package dpac_pkg;
   // -----------------------------------------------------------------
   // Clock and widths
   // -----------------------------------------------------------------
   localparam int CLK_NS = 100;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 16;
   localparam int TMR_W  = 4;

   // -----------------------------------------------------------------
   // Device timing in ns (slowest grade), and derived cycle counts
   // -----------------------------------------------------------------
   localparam int ADDR_ACCESS_NS                 = 20;
   localparam int READ_CYCLE_NS                  = 20;
   localparam int WRITE_PULSE_NS                 = 15;
   localparam int DATA_SETUP_NS                  = 15;
   localparam int WRITE_PULSE_TO_DATA_NS         = 45;
   localparam int WRITE_DATA_TO_READ_NS          = 30;
   localparam int SLAVE_STROBE_HOLD_AFTER_REL_NS = 15;
   localparam int TOKEN_ADDRESS_ACCESS_NS        = 20;
   localparam int TOKEN_UPDATE_GAP_NS            = 10;
   localparam int TOKEN_WRITE_TO_READ_GAP_NS     = 5;
   localparam int RELEASE_TO_DATA_NS =
      (WRITE_PULSE_TO_DATA_NS - WRITE_PULSE_NS) > (WRITE_DATA_TO_READ_NS - DATA_SETUP_NS) ?
      (WRITE_PULSE_TO_DATA_NS - WRITE_PULSE_NS) : (WRITE_DATA_TO_READ_NS - DATA_SETUP_NS);
   localparam int TOKEN_GAP_NS = TOKEN_UPDATE_GAP_NS > TOKEN_WRITE_TO_READ_GAP_NS ?
                                 TOKEN_UPDATE_GAP_NS : TOKEN_WRITE_TO_READ_GAP_NS;

   localparam int ACCESS_CYC     = (ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC      = (WRITE_PULSE_NS + DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC       = (SLAVE_STROBE_HOLD_AFTER_REL_NS + CLK_NS - 1) / CLK_NS;
   localparam int REL_DATA_CYC   = (RELEASE_TO_DATA_NS + CLK_NS - 1) / CLK_NS;
   localparam int TOKEN_ACC_CYC  = (TOKEN_ADDRESS_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int TOKEN_GAP_CYC  = (TOKEN_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESUME_CYC     = (READ_CYCLE_NS + CLK_NS - 1) / CLK_NS + 1;

   // -----------------------------------------------------------------
   // Fields and encodings
   // -----------------------------------------------------------------
   localparam int TOKEN_IDX_W = 3;
   localparam int TOKEN_BIT   = 0;
   localparam int LANE_UPPER  = 1;
   localparam int LANE_LOWER  = 0;

   typedef enum logic [1:0] {
      DPAC_OP_RAM_READ    = 2'h0,
      DPAC_OP_RAM_WRITE   = 2'h1,
      DPAC_OP_TOKEN_READ  = 2'h2,
      DPAC_OP_TOKEN_WRITE = 2'h3
   } dpac_op_t;

   typedef enum logic [7:0] {
      DPAC_IDLE     = 8'h01,
      DPAC_SETUP    = 8'h02,
      DPAC_STROBE   = 8'h04,
      DPAC_WAITBUSY = 8'h08,
      DPAC_HOLD     = 8'h10,
      DPAC_RECOVER  = 8'h20,
      DPAC_STANDBY  = 8'h40,
      DPAC_RESUME   = 8'h80
   } dpac_state_t;
endpackage

// ---- hdl/dpac_tmr_if.sv ----
// Interface between the port sequencer and its cycle timer
`timescale 1ns/100ps
interface dpac_tmr_if;
   logic                          load;
   logic [dpac_pkg::TMR_W-1:0]    count;
   logic                          expired;
   modport ctl (output load, output count, input expired);
   modport tmr (input load, input count, output expired);
endinterface

// ---- hdl/dpac_timer.sv ----
// Down-counting cycle timer for pin sequencing
`timescale 1ns/100ps
module dpac_timer (
   input wire logic sys_clk,
   input wire logic rstn,
   dpac_tmr_if.tmr  tmr
);
   import dpac_pkg::*;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
   } dpac_tmr_t;

   dpac_tmr_t state_ff;
   dpac_tmr_t nxt_state;

   // A load of N makes the waiting state last N cycles
   always_comb begin
      nxt_state = state_ff;
      if (tmr.load) begin
         nxt_state.cnt = tmr.count;
      end else if (state_ff.cnt != '0) begin
         nxt_state.cnt = state_ff.cnt - 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Expiry looks only at the count, so the sequencer's load cannot loop back into it
   assign tmr.expired = (state_ff.cnt <= 4'h1);
endmodule

// ---- hdl/dpac_mbox.sv ----
// Mailbox interrupt watcher for the port's interrupt pin
`timescale 1ns/100ps
module dpac_mbox (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic pin_int_n,
   output logic      mbox_pending,
   output logic      mbox_event
);
   import dpac_pkg::*;

   typedef struct packed {
      logic pending;
      logic event_p;
   } dpac_mbox_t;

   dpac_mbox_t state_ff;
   dpac_mbox_t nxt_state;

   // Pin is synchronous; set and clear are done by the device itself
   always_comb begin
      nxt_state         = state_ff;
      nxt_state.pending = !pin_int_n;
      nxt_state.event_p = !pin_int_n && !state_ff.pending;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign mbox_pending = state_ff.pending;
   assign mbox_event   = state_ff.event_p;
endmodule

// ---- hdl/dpac_port_ctrl.sv ----
// Host-side port sequencer for one port of an asynchronous dual-port RAM
// -----------------------------------------------------------------
// Function
// (R1) Device flags loser low after address match
// (R2) Device releases flag after address mismatch
// (R3) Device flags port selected onto matching address
// (R4) Device releases flag when winner deselects
// (R5) Colliding accesses need priority setup spacing
// (R6) Slave strobe rises only after flag settles
// (R7) Slave strobe held low after flag release
// (R8) Blocked read data valid after release
// (R9) Release-to-data delay is a derived figure
// (R10) Deselect token between write and read
// (R11) Gap between token write and read
// (R12) Simultaneous token requests grant one side
// (R13) Token read data valid after address
// (R14) Array versus token select pin patterns
// (R15) Upper lane only uses upper lane select
// (R16) Strobe high during address change and reads
// (R17) Write needs select and lane low together
// (R18) Strobe length with output enable low
// (R19) Late select keeps outputs high impedance
// (R20) Never drive data while device drives
// (R21) Token reads toggle token select each time
// (R22) Standby holds select high, resume delayed
// (R23) Mailbox write raises owner interrupt
// (R24) Role pin chooses flag direction
// (R25) Token write uses data bit zero only
// (R26) Low three address bits pick token
// (R27) Losing master port write is inhibited
// (R28) Interrupt follows mailbox access promptly
// -----------------------------------------------------------------
`timescale 1ns/100ps
module dpac_port_ctrl #(
   parameter int AW = dpac_pkg::ADDR_W,
   parameter int DW = dpac_pkg::DATA_W
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire logic                 usr_req,
   input  wire dpac_pkg::dpac_op_t   usr_op,
   input  wire logic [AW-1:0]        usr_addr,
   input  wire logic [DW-1:0]        usr_wdata,
   input  wire logic [1:0]           usr_lane_en,
   input  wire logic                 usr_standby,
   output logic                      usr_ready,
   output logic                      usr_done,
   output logic [DW-1:0]             usr_rdata,
   output logic                      usr_blocked,
   output logic                      usr_token_won,
   output logic                      usr_mbox_pending,
   output logic                      usr_mbox_event,
   output logic [AW-1:0]             pin_addr,
   output logic                      pin_port_sel_n,
   output logic                      token_latch_select_n,
   output logic                      upper_lane_select_n,
   output logic                      lower_lane_select_n,
   output logic                      pin_write_n,
   output logic                      pin_out_en_n,
   input  wire logic [DW-1:0]        pin_dq_in,
   output logic [DW-1:0]             pin_dq_out,
   output logic                      pin_dq_oe,
   input  wire logic                 pin_contention_n,
   input  wire logic                 pin_int_n
);
   import dpac_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      dpac_state_t   st;
      logic          write_op;
      logic          token_op;
      logic [AW-1:0] addr;
      logic          port_sel_n;
      logic          token_n;
      logic          upper_n;
      logic          lower_n;
      logic          write_n;
      logic          out_en_n;
      logic [DW-1:0] dq;
      logic          dq_oe;
      logic [DW-1:0] rdata;
      logic          done;
      logic          blocked;
      logic          token_won;
   } dpac_main_t;

   dpac_main_t state_ff;
   dpac_main_t nxt_state;

   dpac_tmr_if tmr_bus ();

   dpac_timer u_timer (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .tmr     (tmr_bus.tmr)
   );

   dpac_mbox u_mbox (
      .sys_clk      (sys_clk),
      .rstn         (rstn),
      .pin_int_n    (pin_int_n),
      .mbox_pending (usr_mbox_pending),
      .mbox_event   (usr_mbox_event)
   );

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   always_comb begin
      nxt_state     = state_ff;
      nxt_state.done = 1'b0;
      tmr_bus.load  = 1'b0;
      tmr_bus.count = '0;
      unique case (state_ff.st)
         DPAC_IDLE: begin
            if (usr_standby) begin
               nxt_state.st = DPAC_STANDBY;
            end else if (usr_req) begin
               // Strobe stays high while the address moves; see (R16)
               nxt_state.write_op = usr_op[0];
               nxt_state.token_op = usr_op[1];
               nxt_state.write_n  = 1'b1;
               nxt_state.blocked  = 1'b0;
               nxt_state.st       = DPAC_SETUP;
               if (usr_op[1]) begin
                  // Only the low bits matter for a token; see (R26)
                  nxt_state.addr = '0;
                  nxt_state.addr[TOKEN_IDX_W-1:0] = usr_addr[TOKEN_IDX_W-1:0];
                  // Token pattern: port select high, token select low; see (R14)
                  nxt_state.port_sel_n = 1'b1;
                  nxt_state.token_n    = 1'b0;
                  // A lane must be low for the token write to land; see (R17)
                  nxt_state.upper_n    = 1'b0;
                  nxt_state.lower_n    = 1'b0;
                  // Request is a zero, release is a one, on bit zero; see (R25)
                  nxt_state.dq = '0;
                  nxt_state.dq[TOKEN_BIT] = usr_wdata[TOKEN_BIT];
               end else begin
                  nxt_state.addr       = usr_addr;
                  // Array pattern, upper-only when just that lane is asked; see (R14) (R15)
                  nxt_state.port_sel_n = 1'b0;
                  nxt_state.token_n    = 1'b1;
                  nxt_state.upper_n    = !usr_lane_en[LANE_UPPER];
                  nxt_state.lower_n    = !usr_lane_en[LANE_LOWER];
                  if (usr_lane_en == 2'h0) begin
                     nxt_state.upper_n = 1'b0;
                     nxt_state.lower_n = 1'b0;
                  end
                  nxt_state.dq = usr_wdata;
               end
            end
         end
         DPAC_SETUP: begin
            // Selects fall a cycle before the strobe, so a read never starts late; see (R19)
            nxt_state.out_en_n = state_ff.write_op;
            tmr_bus.load  = 1'b1;
            if (state_ff.write_op) begin
               // Output enable stays high in writes; the strobe is timed from write pulse plus data setup; see (R18)
               tmr_bus.count = TMR_W'(PULSE_CYC);
               nxt_state.write_n = 1'b0;
               // Device outputs are off because output enable is high; see (R20)
               nxt_state.dq_oe   = 1'b1;
            end else begin
               tmr_bus.count = state_ff.token_op ? TMR_W'(TOKEN_ACC_CYC) : TMR_W'(ACCESS_CYC); // see (R13)
            end
            nxt_state.st = DPAC_STROBE;
         end
         DPAC_STROBE: begin
            if (tmr_bus.expired) begin
               if (!pin_contention_n && !state_ff.token_op) begin
                  // Lost arbitration: keep the cycle open until release; see (R6) (R27)
                  nxt_state.blocked = 1'b1;
                  nxt_state.st      = DPAC_WAITBUSY;
               end else begin
                  nxt_state.rdata    = state_ff.write_op ? state_ff.rdata : pin_dq_in;
                  nxt_state.token_won = state_ff.token_op && !state_ff.write_op ?
                                        !pin_dq_in[TOKEN_BIT] : state_ff.token_won;
                  nxt_state.st       = DPAC_RECOVER;
               end
            end
         end
         DPAC_WAITBUSY: begin
            if (pin_contention_n) begin
               tmr_bus.load  = 1'b1;
               // Hold the strobe after release, or wait for blocked data; see (R7) (R8) (R9)
               tmr_bus.count = state_ff.write_op ? TMR_W'(HOLD_CYC) : TMR_W'(REL_DATA_CYC);
               nxt_state.st  = DPAC_HOLD;
            end
         end
         DPAC_HOLD: begin
            if (tmr_bus.expired) begin
               nxt_state.rdata = state_ff.write_op ? state_ff.rdata : pin_dq_in;
               nxt_state.st    = DPAC_RECOVER;
            end
         end
         DPAC_STANDBY: begin
            if (!usr_standby) begin
               tmr_bus.load  = 1'b1;
               // Resume only after more than one read cycle; see (R22)
               tmr_bus.count = TMR_W'(RESUME_CYC);
               nxt_state.st  = DPAC_RESUME;
            end
         end
         DPAC_RESUME: begin
            if (tmr_bus.expired) begin
               nxt_state.st = DPAC_IDLE;
            end
         end
         DPAC_RECOVER: begin
            if (tmr_bus.expired) begin
               nxt_state.st = DPAC_IDLE;
            end
         end
      endcase
      // Closing a cycle: everything deselected and the gap timed; see (R10) (R11) (R21)
      if (nxt_state.st == DPAC_RECOVER && state_ff.st != DPAC_RECOVER) begin
         nxt_state.write_n    = 1'b1;
         nxt_state.out_en_n   = 1'b1;
         nxt_state.dq_oe      = 1'b0;
         nxt_state.port_sel_n = 1'b1;
         nxt_state.token_n    = 1'b1;
         nxt_state.upper_n    = 1'b1;
         nxt_state.lower_n    = 1'b1;
         nxt_state.done       = 1'b1;
         tmr_bus.load         = 1'b1;
         tmr_bus.count        = TMR_W'(TOKEN_GAP_CYC);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff            <= '0;
         state_ff.st         <= DPAC_IDLE;
         state_ff.port_sel_n <= 1'b1;
         state_ff.token_n    <= 1'b1;
         state_ff.upper_n    <= 1'b1;
         state_ff.lower_n    <= 1'b1;
         state_ff.write_n    <= 1'b1;
         state_ff.out_en_n   <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Both ports must space colliding accesses; only the system can do that; see (R5)
   assign usr_ready            = (state_ff.st == DPAC_IDLE) && !usr_standby;
   assign usr_done             = state_ff.done;
   assign usr_rdata            = state_ff.rdata;
   assign usr_blocked          = state_ff.blocked;
   assign usr_token_won        = state_ff.token_won;
   assign pin_addr             = state_ff.addr;
   assign pin_port_sel_n       = state_ff.port_sel_n;
   assign token_latch_select_n = state_ff.token_n;
   assign upper_lane_select_n  = state_ff.upper_n;
   assign lower_lane_select_n  = state_ff.lower_n;
   assign pin_write_n          = state_ff.write_n;
   assign pin_out_en_n         = state_ff.out_en_n;
   assign pin_dq_out           = state_ff.dq;
   assign pin_dq_oe            = state_ff.dq_oe;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   AST_ADDR_STROBE_HIGH: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R16)
      $changed(pin_addr) |-> pin_write_n && $past(pin_write_n))
      else $error("Address moved with write strobe low");
   AST_ARRAY_PATTERN: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R14)
      !pin_port_sel_n |-> token_latch_select_n && !(upper_lane_select_n && lower_lane_select_n))
      else $error("Array access with bad select pattern");
   AST_TOKEN_PATTERN: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R14)
      !token_latch_select_n |-> pin_port_sel_n && (pin_addr >> TOKEN_IDX_W) == '0)
      else $error("Token access with port select low");
   AST_UPPER_ONLY: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R15)
      usr_ready && usr_req && usr_op == DPAC_OP_RAM_WRITE && usr_lane_en == 2'h2
      |=> !upper_lane_select_n && lower_lane_select_n && !pin_port_sel_n)
      else $error("Upper lane access not upper only");
   AST_NO_DRIVE_CLASH: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R20)
      (pin_dq_oe || !pin_write_n) |-> pin_out_en_n)
      else $error("Data driven while device may drive");
   AST_STROBE_BUSY: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R6)
      !pin_contention_n && !pin_write_n && state_ff.st != DPAC_STROBE |=> !pin_write_n)
      else $error("Write strobe rose while flag active");
   AST_STROBE_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R7)
      state_ff.st == DPAC_WAITBUSY && pin_contention_n && state_ff.write_op
      |=> !pin_write_n [*1] ##1 pin_write_n)
      else $error("Write strobe not held after flag release");
   AST_TOKEN_GAP: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R10)
      $rose(token_latch_select_n) |=> token_latch_select_n)
      else $error("Token select not held off between accesses");
   AST_STANDBY: assert property (@(posedge sys_clk) disable iff (!rstn) // see (R22)
      state_ff.st == DPAC_STANDBY |-> pin_port_sel_n && token_latch_select_n ##1
      (state_ff.st != DPAC_IDLE))
      else $error("Standby left without resume wait");
endmodule

// ---- testbench/dpac_dev_model.sv ----
// Behavioural model of one port of the dual-port RAM, as the controller sees it
`timescale 1ns/100ps
module dpac_dev_model
   import dpac_pkg::*;
#(
   parameter logic [ADDR_W-1:0] OWN_BOX  = 15'h7ffe,
   parameter logic [ADDR_W-1:0] PEER_BOX = 15'h7fff
) (
   input  wire logic [ADDR_W-1:0] pin_addr,
   input  wire logic              pin_port_sel_n,
   input  wire logic              token_latch_select_n,
   input  wire logic              upper_lane_select_n,
   input  wire logic              lower_lane_select_n,
   input  wire logic              pin_write_n,
   input  wire logic              pin_out_en_n,
   input  wire logic [DATA_W-1:0] pin_dq_out,
   input  wire logic              pin_dq_oe,
   input  wire logic              busy,
   input  wire logic              peer_wr,
   output logic      [DATA_W-1:0] pin_dq_in,
   output logic                   pin_contention_n,
   output logic                   pin_int_n,
   output logic                   peer_int_n,
   output logic                   viol
);
   logic [DATA_W-1:0] mem [0:255];
   logic [7:0]        tok = 8'hff;
   logic [DATA_W-1:0] word;
   logic [DATA_W-1:0] last = 16'h0000;
   logic              sel;
   logic              drv;
   logic              wr;
   initial pin_int_n = 1'b1;
   initial peer_int_n = 1'b1;
   initial viol = 1'b0;
   assign sel = !pin_port_sel_n || !token_latch_select_n;
   assign drv = sel && !pin_out_en_n && pin_write_n;
   assign wr = sel && !pin_write_n;
   // Master role: flags are outputs, the bench plays the arbiter
   assign pin_contention_n = !busy;
   assign word = token_latch_select_n ? mem[pin_addr[7:0]] : {DATA_W{tok[pin_addr[2:0]]}};
   // Released bus shows the inverse so a stale sample cannot pass
   assign pin_dq_in = drv ? word : ~last;
   always @(word or drv) if (drv) last = word;
   // Level-sensitive cell: the word follows the data while the pulse lasts
   always @* begin
      if (wr && !token_latch_select_n) tok[pin_addr[2:0]] = pin_dq_out[0];
      if (wr && !busy && token_latch_select_n) begin
         if (!lower_lane_select_n) mem[pin_addr[7:0]][7:0] = pin_dq_out[7:0];
         if (!upper_lane_select_n) mem[pin_addr[7:0]][15:8] = pin_dq_out[15:8];
         if (pin_addr == PEER_BOX) peer_int_n = 1'b0;
      end
      if (drv && token_latch_select_n && pin_addr == OWN_BOX) pin_int_n = 1'b1;
   end
   always @(posedge peer_wr) pin_int_n = 1'b0;
   // Checks on the controller side; 1 ns lets one edge's updates land
   always @(pin_addr) #1 if (!pin_write_n) viol = 1'b1;
   always @(pin_port_sel_n or token_latch_select_n or pin_dq_oe or pin_out_en_n) #1
      if ((!pin_port_sel_n && !token_latch_select_n) || (pin_dq_oe && drv)) viol = 1'b1;
endmodule

// ---- testbench/dpac_port_ctrl_tb_top.sv ----
// Self-checking bench for the port sequencer against the device model
`timescale 1ns/100ps
module dpac_port_ctrl_tb_top;
   import dpac_pkg::*;
   localparam dpac_op_t RD = DPAC_OP_RAM_READ;
   localparam dpac_op_t WR = DPAC_OP_RAM_WRITE;
   localparam dpac_op_t TR = DPAC_OP_TOKEN_READ;
   localparam dpac_op_t TW = DPAC_OP_TOKEN_WRITE;
   logic              sys_clk = 1'b0;
   logic              rstn, usr_req, usr_standby, busy, peer_wr, ev_seen, wr_at_rel;
   dpac_op_t          usr_op;
   logic [ADDR_W-1:0] usr_addr, pin_addr;
   logic [DATA_W-1:0] usr_wdata, usr_rdata, pin_dq_in, pin_dq_out;
   logic [1:0]        usr_lane_en;
   logic              usr_ready, usr_done, usr_blocked, usr_token_won, usr_mbox_pending, usr_mbox_event;
   logic              pin_port_sel_n, token_latch_select_n, upper_lane_select_n, lower_lane_select_n;
   logic              pin_write_n, pin_out_en_n, pin_dq_oe, pin_contention_n, pin_int_n, peer_int_n, viol;
   int                err_count, n_checks, n;

   dpac_port_ctrl i_dut (.sys_clk, .rstn, .usr_req, .usr_op, .usr_addr, .usr_wdata, .usr_lane_en,
      .usr_standby, .usr_ready, .usr_done, .usr_rdata, .usr_blocked, .usr_token_won, .usr_mbox_pending,
      .usr_mbox_event, .pin_addr, .pin_port_sel_n, .token_latch_select_n, .upper_lane_select_n,
      .lower_lane_select_n, .pin_write_n, .pin_out_en_n, .pin_dq_in, .pin_dq_out, .pin_dq_oe,
      .pin_contention_n, .pin_int_n);
   dpac_dev_model i_dev (.pin_addr, .pin_port_sel_n, .token_latch_select_n, .upper_lane_select_n,
      .lower_lane_select_n, .pin_write_n, .pin_out_en_n, .pin_dq_out, .pin_dq_oe, .busy, .peer_wr,
      .pin_dq_in, .pin_contention_n, .pin_int_n, .peer_int_n, .viol);

   always #(CLK_NS / 2) sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (usr_mbox_event === 1'b1) ev_seen <= 1'b1;

   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   // One access; entered and left at a falling edge. The flag drops at cycle hold.
   task automatic acc(input dpac_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d = 16'h0000,
                      input logic [1:0] ln = 2'b11, input int hold = 0);
      usr_op = op;
      usr_addr = a;
      usr_wdata = d;
      usr_lane_en = ln;
      usr_req = 1'b1;
      while (usr_ready !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      usr_req = 1'b0;
      n = 1;
      while (usr_done !== 1'b1 && n < 40) begin
         if (n == hold) busy = 1'b0;
         @(negedge sys_clk);
         n++;
         if (n == hold + 1) wr_at_rel = pin_write_n;
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic t_ram;
      chk(pin_port_sel_n === 1'b1 && token_latch_select_n === 1'b1 && pin_dq_oe === 1'b0, "idle pins");
      acc(WR, 15'h0010, 16'h5a5a);
      chk(n == 3, "write latency");
      acc(RD, 15'h0010);
      chk(n == 3 && usr_rdata === 16'h5a5a, "read back");
      $display("test ram done");
   endtask

   task automatic t_lane;
      logic [DATA_W-1:0] wd [4] = '{16'hffff, 16'h1234, 16'habcd, 16'h0000};
      logic [1:0]        ln [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
      logic [DATA_W-1:0] ex [4] = '{16'hffff, 16'h12ff, 16'h12cd, 16'h0000};
      for (int i = 0; i < 4; i++) begin
         acc(WR, 15'h0020, wd[i], ln[i]);
         acc(RD, 15'h0020);
         chk(usr_rdata === ex[i], "lane write");
      end
      $display("test lane done");
   endtask

   task automatic t_token;
      busy = 1'b1;
      acc(TW, 15'h7ffd, 16'hfffe, 2'b11, 40);
      chk(n == 3, "token ignores flag");
      acc(TR, 15'h0005, 16'h0000, 2'b11, 40);
      chk(usr_token_won === 1'b1 && usr_rdata === 16'h0000, "token won");
      busy = 1'b0;
      acc(TW, 15'h0005, 16'h0001);
      acc(TR, 15'h0005);
      chk(usr_token_won === 1'b0 && usr_rdata === 16'hffff, "token freed");
      $display("test token done");
   endtask

   task automatic t_block;
      busy = 1'b1;
      acc(WR, 15'h0030, 16'hbeef, 2'b11, 4);
      chk(n == 6 && wr_at_rel === 1'b0 && usr_blocked === 1'b1, "blocked write");
      busy = 1'b1;
      acc(RD, 15'h0030, 16'h0000, 2'b11, 3);
      chk(n == 5 && usr_rdata === 16'hbeef, "blocked read");
      acc(RD, 15'h0030);
      chk(usr_blocked === 1'b0 && n == 3, "flag clear");
      $display("test block done");
   endtask

   task automatic t_mbox;
      ev_seen = 1'b0;
      peer_wr = 1'b1;
      @(negedge sys_clk);
      peer_wr = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(usr_mbox_pending === 1'b1 && ev_seen === 1'b1, "mailbox raised");
      acc(RD, 15'h7ffe);
      repeat (2) @(negedge sys_clk);
      chk(usr_mbox_pending === 1'b0, "mailbox cleared");
      acc(WR, 15'h7fff, 16'h00a5);
      chk(peer_int_n === 1'b0, "peer mailbox");
      $display("test mbox done");
   endtask

   task automatic t_standby;
      usr_standby = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk(usr_ready === 1'b0 && pin_port_sel_n === 1'b1 && token_latch_select_n === 1'b1, "standby");
      usr_standby = 1'b0;
      @(negedge sys_clk);
      chk(usr_ready === 1'b0, "resume wait");
      n = 0;
      while (usr_ready !== 1'b1 && n < 10) begin
         @(negedge sys_clk);
         n++;
      end
      chk(usr_ready === 1'b1 && n == RESUME_CYC, "resumed");
      $display("test standby done");
   endtask

   initial begin
      rstn = 1'b0;
      usr_req = 1'b0;
      usr_op = RD;
      usr_addr = 15'h0000;
      usr_wdata = 16'h0000;
      usr_lane_en = 2'b11;
      usr_standby = 1'b0;
      busy = 1'b0;
      peer_wr = 1'b0;
      err_count = 0;
      n_checks = 0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      t_ram;
      t_lane;
      t_token;
      t_block;
      t_mbox;
      t_standby;
      chk(viol === 1'b0, "pin protocol");
      test_done;
   end

   // Whole run needs about 90 cycles
   initial begin
      #(CLK_NS * 3000);
      err_count++;
      $display("BAD %0t watchdog", $time);
      test_done;
   end
endmodule
